// ### bench/dfs_motor.sv
`timescale 1ns/1ns
`default_nettype none
// -------------------------------------------
// Motor and power stage
// -------------------------------------------
module dfs_motor (
    input wire logic clock,
    input wire logic rst,
    input wire logic drive_en,
    input wire logic [15:0] ref_sum,
    output logic [15:0] motor_speed
);
    // Coasts without drive
    // Slow slopes keep ramping visible for many cycles
    always_ff @(posedge clock) begin
        if (rst) begin
            motor_speed <= 16'h0000;
        end else if (drive_en && motor_speed < ref_sum) begin
            motor_speed <= motor_speed + 16'h0001;
        end else if (!drive_en && motor_speed != 16'h0000) begin
            motor_speed <= motor_speed - 16'h0001;
        end
    end
endmodule : dfs_motor
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dfs_pkg::*;
    logic clock, rst, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdat;
    logic di_start_fwd, di_start_rev, di_stop, di_fast_halt_n, di_reset;
    logic di_permit, panel_start, panel_stop, panel_reset;
    logic crit_overstress, inv_fault_trip, alarm_req, alarm_latching;
    logic alarm_cause, warn_cond, supply_low, power_cycled;
    logic sleep_req, wake_demand, drive_en, fast_halt_ramp, ramping;
    logic dir_rev, disp_flash, light_power, light_warn, light_alarm;
    logic [7:0] alarm_code, warn_code, disp_code;
    logic [15:0] ref_sum, motor_speed, switch_freq;
    logic [9:0] op_status;
    logic [31:0] cfg [5] = '{32'h8, 32'h4, 32'hc, 32'h8, 32'h5};
    int mismatches, samples_checked;
    // -------------------------------------------
    // Design and far side
    // -------------------------------------------
    // Short counts keep the run brief
    dfs_supervisor #(.DERATE_CYCLES(20), .BLINK_CYCLES(4)) i_dut (.*);
    dfs_motor i_motor (.*);
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // -------------------------------------------
    // Tasks
    // -------------------------------------------
    task end_of_test;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Request holds until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clock);
            n++;
            if (n > 50) begin
                mismatches++;
                end_of_test;
            end
        end while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task wt(input dfs_state_e e);
        int n;
        n = 0;
        while (op_status !== e) begin
            @(posedge clock);
            n++;
            if (n > 300) begin
                mismatches++;
                end_of_test;
            end
        end
        chk(32'(op_status), 32'(e));
    endtask : wt
    logic la_seen;
    // -------------------------------------------
    // Sequence
    // -------------------------------------------
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata, di_start_fwd,
            di_start_rev, di_stop, di_reset, di_permit, panel_start,
            panel_stop, panel_reset, crit_overstress, inv_fault_trip,
            alarm_req, alarm_latching, alarm_cause, warn_cond, warn_code,
            supply_low, power_cycled, sleep_req, wake_demand} = '0;
        di_fast_halt_n = 1'b1;
        ref_sum = 16'h0010;
        alarm_code = 8'h0d;
        rst = 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk(32'(op_status), 32'(DFS_ST_STOP));
        chk(32'(switch_freq), 32'(SW_HZ_NORMAL));
        chk(32'(light_power), 32'h1);
        bus(1'b0, 4'hf, 32'h0);
        chk(rdat, 32'h0);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 4'(i + 1), cfg[i]);
            bus(1'b0, 4'(i + 1), 32'h0);
            chk(rdat, cfg[i]);
        end
        bus(1'b1, ADDR_CTRL, 32'h4);
        bus(1'b0, ADDR_FLAGS, 32'h0);
        chk(32'(rdat[3:0]), 32'h9);
        di_start_fwd <= 1'b1;
        wt(DFS_ST_RUNREQ);
        chk(32'(drive_en), 32'h0);
        di_permit <= 1'b1;
        wt(DFS_ST_DELAY);
        chk(32'(drive_en), 32'h0);
        wt(DFS_ST_RUN);
        di_start_fwd <= 1'b0;
        repeat (3) @(posedge clock);
        chk(32'(ramping), 32'h1);
        chk(32'(dir_rev), 32'h0);
        repeat (40) @(posedge clock);
        chk(32'(ramping), 32'h0);
        bus(1'b0, ADDR_FLAGS, 32'h0);
        chk(32'(rdat[3:0]), 32'h5);
        di_fast_halt_n <= 1'b0;
        wt(DFS_ST_QSTOP);
        chk(32'(fast_halt_ramp), 32'h1);
        di_fast_halt_n <= 1'b1;
        bus(1'b1, ADDR_CMD, 32'h2);
        wt(DFS_ST_STOP);
        di_start_rev <= 1'b1;
        wt(DFS_ST_RUN);
        di_start_rev <= 1'b0;
        repeat (3) @(posedge clock);
        chk(32'(dir_rev), 32'h1);
        crit_overstress <= 1'b1;
        @(posedge clock);
        crit_overstress <= 1'b0;
        repeat (4) @(posedge clock);
        chk(32'(switch_freq), 32'(SW_HZ_DERATE));
        chk(32'(op_status), 32'(DFS_ST_DERATE));
        repeat (22) @(posedge clock);
        chk(32'(switch_freq), 32'(SW_HZ_NORMAL));
        panel_stop <= 1'b1;
        repeat (6) @(posedge clock);
        panel_stop <= 1'b0;
        wt(DFS_ST_STOP);
        alarm_cause <= 1'b1;
        alarm_req <= 1'b1;
        repeat (6) @(posedge clock);
        alarm_req <= 1'b0;
        wt(DFS_ST_TRIP);
        chk(32'(drive_en), 32'h0);
        chk({light_warn, disp_flash, disp_code}, 32'h10d);
        la_seen = light_alarm;
        repeat (4) @(posedge clock);
        chk(32'(light_alarm ^ la_seen), 32'h1);
        panel_reset <= 1'b1;
        repeat (6) @(posedge clock);
        panel_reset <= 1'b0;
        repeat (6) @(posedge clock);
        chk(32'(op_status), 32'(DFS_ST_TRIP));
        alarm_cause <= 1'b0;
        panel_reset <= 1'b1;
        repeat (6) @(posedge clock);
        panel_reset <= 1'b0;
        wt(DFS_ST_STOP);
        alarm_latching <= 1'b1;
        alarm_cause <= 1'b1;
        alarm_req <= 1'b1;
        repeat (6) @(posedge clock);
        alarm_req <= 1'b0;
        wt(DFS_ST_LOCK);
        chk(32'(light_warn), 32'h1);
        alarm_cause <= 1'b0;
        di_reset <= 1'b1;
        repeat (6) @(posedge clock);
        di_reset <= 1'b0;
        repeat (6) @(posedge clock);
        chk(32'(op_status), 32'(DFS_ST_LOCK));
        power_cycled <= 1'b1;
        repeat (6) @(posedge clock);
        power_cycled <= 1'b0;
        di_reset <= 1'b1;
        repeat (6) @(posedge clock);
        di_reset <= 1'b0;
        wt(DFS_ST_STOP);
        supply_low <= 1'b1;
        repeat (6) @(posedge clock);
        chk({light_warn, light_alarm, disp_flash, disp_code}, 32'h401);
        supply_low <= 1'b0;
        repeat (6) @(posedge clock);
        chk(32'(light_warn), 32'h0);
        warn_cond <= 1'b1;
        warn_code <= 8'h07;
        repeat (3) @(posedge clock);
        chk({light_warn, disp_flash, disp_code}, 32'h207);
        warn_cond <= 1'b0;
        bus(1'b1, ADDR_CTRL, 32'h1);
        wt(DFS_ST_STANDBY);
        panel_start <= 1'b1;
        repeat (10) @(posedge clock);
        chk(32'(op_status), 32'(DFS_ST_STANDBY));
        panel_start <= 1'b0;
        bus(1'b1, ADDR_CMD, 32'h1);
        wt(DFS_ST_RUN);
        chk(32'(dir_rev), 32'h0);
        sleep_req <= 1'b1;
        wt(DFS_ST_SLEEP);
        chk(32'(drive_en), 32'h0);
        sleep_req <= 1'b0;
        wake_demand <= 1'b1;
        wt(DFS_ST_RUN);
        wake_demand <= 1'b0;
        repeat (20) @(posedge clock);
        bus(1'b1, ADDR_CMD, 32'h4);
        wt(DFS_ST_QSTOP);
        chk(32'(drive_en), 32'h0);
        bus(1'b1, ADDR_CMD, 32'h2);
        wt(DFS_ST_STANDBY);
        crit_overstress <= 1'b1;
        @(posedge clock);
        crit_overstress <= 1'b0;
        inv_fault_trip <= 1'b1;
        repeat (4) @(posedge clock);
        chk(32'(switch_freq), 32'(SW_HZ_NORMAL));
        inv_fault_trip <= 1'b0;
        end_of_test;
    end
endmodule : tb
`default_nettype wire

// ### hw/dfs_pkg.sv
package dfs_pkg;
    // Register word indices
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_REFHI = 4'h1;
    localparam logic [3:0] ADDR_REFLO = 4'h2;
    localparam logic [3:0] ADDR_SPDHI = 4'h3;
    localparam logic [3:0] ADDR_SPDLO = 4'h4;
    localparam logic [3:0] ADDR_DELAY = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_FLAGS = 4'h7;
    localparam logic [3:0] ADDR_CMD = 4'h8;
    // Control register fields
    localparam int CTRL_AUTO = 0;
    localparam int CTRL_AUTORST = 1;
    localparam int CTRL_PERMIT_EN = 2;
    // Serial command bits
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_QSTOP = 2;
    localparam int CMD_RESET = 3;
    localparam int CMD_REV = 4;
    // Flag register fields
    localparam int FLG_REFHI = 0;
    localparam int FLG_REFLO = 1;
    localparam int FLG_SPDHI = 2;
    localparam int FLG_SPDLO = 3;
    localparam int FLG_WARN = 4;
    localparam int FLG_DERATE = 5;
    localparam int FLG_DIR = 6;
    localparam int FLG_PEND = 7;
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int DERATE_S = 10;
    localparam int BLINK_MS = 250;
    localparam int DERATE_CYC = CLK_HZ * DERATE_S;
    localparam int BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
    localparam logic [15:0] SW_HZ_DERATE = 16'h0fa0;
    localparam logic [15:0] SW_HZ_NORMAL = 16'h1f40;
    localparam logic [7:0] WARN_NUM_SUPPLY = 8'h01;
    // Reported status, one-hot
    typedef enum logic [9:0] {
        DFS_ST_STOP = 10'h001,
        DFS_ST_STANDBY = 10'h002,
        DFS_ST_RUNREQ = 10'h004,
        DFS_ST_DELAY = 10'h008,
        DFS_ST_RUN = 10'h010,
        DFS_ST_QSTOP = 10'h020,
        DFS_ST_SLEEP = 10'h040,
        DFS_ST_DERATE = 10'h080,
        DFS_ST_TRIP = 10'h100,
        DFS_ST_LOCK = 10'h200
    } dfs_state_e;
endpackage : dfs_pkg

// ### hw/dfs_supervisor.sv
// Function
// - Critical overcurrent or overvoltage enters derating, switching drops to 4 kHz.
// - Derating ends after about 10 s if the condition allows; delay may restrict.
// - Fast-halt ramp when inverted fast-halt input inactive or serial fast halt.
// - Ramping status while motor speed has not reached reference or standstill.
// - Reference above upper limit or below lower limit raises a flag.
// - Speed above upper or below lower warning limit raises a flag.
// - Start held as pending request until run permissive input arrives.
// - Nonzero start delay must elapse before the motor is driven.
// - Forward or reverse start input sets the running direction.
// - Automatic mode waits in standby for input or serial start.
// - Stop from panel, input or serial link enters stop status.
// - Sleep keeps motor stopped and restarts automatically on demand.
// - Automatic mode ignores panel commands, obeys external ones.
// - Warnings follow their condition and clear by themselves.
// - Every alarm trips or trip-locks; operation waits for a reset.
// - Trip removes drive so the motor coasts; monitoring continues.
// - Ordinary trip cleared by panel, input, serial or auto reset.
// - Trip lock accepts reset only after a power cycle.
// - Trip reports motor stopped; reset accepted once cause clears.
// - Warning shown steady with number; alarm flashes with number.
// - Three lights: warning, alarm flashing, trip lock both.
// - Auxiliary supply below 10 V raises warning number 1.
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module dfs_supervisor #(
    parameter int DERATE_CYCLES = dfs_pkg::DERATE_CYC,
    parameter int BLINK_CYCLES = dfs_pkg::BLINK_CYC,
    parameter int NUM_DI = 6
) (
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Digital inputs, raw pins
    input wire logic di_start_fwd,
    input wire logic di_start_rev,
    input wire logic di_stop,
    input wire logic di_fast_halt_n,
    input wire logic di_reset,
    input wire logic di_permit,
    // Operator panel keys, raw pins
    input wire logic panel_start,
    input wire logic panel_stop,
    input wire logic panel_reset,
    // Power stage monitors, same clock domain
    input wire logic crit_overstress,
    input wire logic inv_fault_trip,
    input wire logic alarm_req,
    input wire logic alarm_latching,
    input wire logic [7:0] alarm_code,
    input wire logic alarm_cause,
    input wire logic warn_cond,
    input wire logic [7:0] warn_code,
    input wire logic supply_low,
    input wire logic power_cycled,
    input wire logic sleep_req,
    input wire logic wake_demand,
    input wire logic [15:0] ref_sum,
    input wire logic [15:0] motor_speed,
    // Outputs
    output logic drive_en,
    output logic fast_halt_ramp,
    output logic ramping,
    output logic dir_rev,
    output logic [15:0] switch_freq,
    output logic [9:0] op_status,
    output logic [7:0] disp_code,
    output logic disp_flash,
    output logic light_power,
    output logic light_warn,
    output logic light_alarm
);
    import dfs_pkg::*;

    // ------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------
    localparam int NS = NUM_DI + 3;
    localparam int IDX_HALT = 3;
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
    assign pin_raw = {panel_reset, panel_stop, panel_start, di_permit,
        di_reset, di_fast_halt_n, di_stop, di_start_rev, di_start_fwd};
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (rst) begin
                    // Halt pin idles high; a low reset would fake a halt
                    s1_ff[gi] <= (gi == IDX_HALT);
                    s2_ff[gi] <= (gi == IDX_HALT);
                    s3_ff[gi] <= (gi == IDX_HALT);
                    pin_ff[gi] <= (gi == IDX_HALT);
                end else begin
                    s1_ff[gi] <= pin_raw[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    if (s2_ff[gi] == s3_ff[gi]) begin
                        pin_ff[gi] <= s3_ff[gi];
                    end
                end
            end
        end
    endgenerate
    logic i_fwd, i_rev, i_stop, i_halt_n, i_rst, i_permit;
    logic k_start, k_stop, k_rst;
    assign {k_rst, k_stop, k_start, i_permit, i_rst, i_halt_n, i_stop,
        i_rev, i_fwd} = pin_ff;

    // ------------------------------------------------
    // Registers
    // ------------------------------------------------
    logic [2:0] ctrl_ff;
    logic [15:0] refhi_ff, reflo_ff, spdhi_ff, spdlo_ff;
    logic [31:0] delay_ff;
    logic [4:0] cmd_ff;
    logic qstop_ser_ff;
    logic bus_ack_ff;
    logic wr_hit, rd_hit;
    assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_ff;
    // Writes land one edge after the wait state, when waitrequest is seen low
    assign wr_hit = avs_write & bus_ack_ff;
    assign rd_hit = avs_read & ~bus_ack_ff;

    always_ff @(posedge clock) begin
        if (rst) begin
            bus_ack_ff <= 1'b0;
        end else begin
            bus_ack_ff <= (avs_read | avs_write) & ~bus_ack_ff;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_ff <= 3'h0;
            refhi_ff <= 16'hffff;
            reflo_ff <= 16'h0000;
            spdhi_ff <= 16'hffff;
            spdlo_ff <= 16'h0000;
            delay_ff <= 32'h0;
        end else if (wr_hit) begin
            unique case (avs_address)
                ADDR_CTRL: ctrl_ff <= avs_writedata[2:0];
                ADDR_REFHI: refhi_ff <= avs_writedata[15:0];
                ADDR_REFLO: reflo_ff <= avs_writedata[15:0];
                ADDR_SPDHI: spdhi_ff <= avs_writedata[15:0];
                ADDR_SPDLO: spdlo_ff <= avs_writedata[15:0];
                ADDR_DELAY: delay_ff <= avs_writedata;
                default: ;
            endcase
        end
    end

    // Serial commands are one-cycle strobes; fast halt is held
    always_ff @(posedge clock) begin
        if (rst) begin
            cmd_ff <= 5'h0;
            qstop_ser_ff <= 1'b0;
        end else begin
            cmd_ff <= (wr_hit && avs_address == ADDR_CMD) ?
                avs_writedata[4:0] : 5'h0;
            if (wr_hit && avs_address == ADDR_CMD) begin
                qstop_ser_ff <= avs_writedata[CMD_QSTOP];
            end
        end
    end

    logic auto_mode;
    assign auto_mode = ctrl_ff[CTRL_AUTO];

    // ------------------------------------------------
    // Command sources
    // ------------------------------------------------
    logic fwd_d_ff, rev_d_ff, kst_d_ff;
    logic start_ev, stop_lvl, reset_ev, rst_d_ff, krst_d_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            fwd_d_ff <= 1'b0;
            rev_d_ff <= 1'b0;
            kst_d_ff <= 1'b0;
            rst_d_ff <= 1'b0;
            krst_d_ff <= 1'b0;
        end else begin
            fwd_d_ff <= i_fwd;
            rev_d_ff <= i_rev;
            kst_d_ff <= k_start;
            rst_d_ff <= i_rst;
            krst_d_ff <= k_rst;
        end
    end
    assign start_ev = (i_fwd & ~fwd_d_ff) | (i_rev & ~rev_d_ff)
        | cmd_ff[CMD_START] | (~auto_mode & k_start & ~kst_d_ff);
    assign stop_lvl = i_stop | cmd_ff[CMD_STOP] | (~auto_mode & k_stop);
    assign reset_ev = (i_rst & ~rst_d_ff) | cmd_ff[CMD_RESET]
        | (~auto_mode & k_rst & ~krst_d_ff) | ctrl_ff[CTRL_AUTORST];

    // ------------------------------------------------
    // Fault latch
    // ------------------------------------------------
    logic trip_ff, lock_ff, armed_ff;
    logic [7:0] alarm_num_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            trip_ff <= 1'b0;
            lock_ff <= 1'b0;
            armed_ff <= 1'b0;
            alarm_num_ff <= 8'h00;
        end else begin
            if (alarm_req) begin
                alarm_num_ff <= alarm_code;
                if (alarm_latching) begin
                    lock_ff <= 1'b1;
                    armed_ff <= 1'b0;
                end else begin
                    trip_ff <= 1'b1;
                end
            end else if (lock_ff) begin
                if (power_cycled) begin
                    armed_ff <= 1'b1;
                end
                if (armed_ff && reset_ev && !alarm_cause) begin
                    lock_ff <= 1'b0;
                    trip_ff <= 1'b0;
                    armed_ff <= 1'b0;
                end
            end else if (trip_ff && reset_ev && !alarm_cause) begin
                trip_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------
    // Derating
    // ------------------------------------------------
    logic derate_ff;
    logic [31:0] der_cnt_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            derate_ff <= 1'b0;
            der_cnt_ff <= 32'h0;
        end else if (trip_ff || lock_ff || inv_fault_trip) begin
            derate_ff <= 1'b0;
            der_cnt_ff <= 32'h0;
        end else if (!derate_ff) begin
            derate_ff <= crit_overstress;
            der_cnt_ff <= 32'h0;
        end else if (der_cnt_ff >= 32'(DERATE_CYCLES - 1)) begin
            derate_ff <= crit_overstress;
            der_cnt_ff <= 32'h0;
        end else begin
            der_cnt_ff <= der_cnt_ff + 32'h1;
        end
    end

    // ------------------------------------------------
    // Run sequencing
    // ------------------------------------------------
    typedef enum logic [4:0] {
        DFS_RS_IDLE = 5'h01,
        DFS_RS_PEND = 5'h02,
        DFS_RS_DELAY = 5'h04,
        DFS_RS_RUN = 5'h08,
        DFS_RS_SLEEP = 5'h10
    } dfs_run_e;
    dfs_run_e run_ff;
    logic [31:0] dly_cnt_ff;
    logic dir_ff;
    logic faulted;
    assign faulted = trip_ff | lock_ff;

    always_ff @(posedge clock) begin
        if (rst) begin
            run_ff <= DFS_RS_IDLE;
            dly_cnt_ff <= 32'h0;
        end else if (faulted || stop_lvl) begin
            run_ff <= DFS_RS_IDLE;
        end else begin
            unique case (run_ff)
                DFS_RS_IDLE: if (start_ev) begin
                    run_ff <= DFS_RS_PEND;
                end
                DFS_RS_PEND: if (i_permit || !ctrl_ff[CTRL_PERMIT_EN]) begin
                    run_ff <= DFS_RS_DELAY;
                    dly_cnt_ff <= 32'h0;
                end
                DFS_RS_DELAY: if (dly_cnt_ff >= delay_ff) begin
                    run_ff <= DFS_RS_RUN;
                end else begin
                    dly_cnt_ff <= dly_cnt_ff + 32'h1;
                end
                DFS_RS_RUN: if (sleep_req) begin
                    run_ff <= DFS_RS_SLEEP;
                end
                DFS_RS_SLEEP: if (wake_demand) begin
                    run_ff <= DFS_RS_RUN;
                end
                default: run_ff <= DFS_RS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            dir_ff <= 1'b0;
        end else if (i_rev & ~rev_d_ff) begin
            dir_ff <= 1'b1;
        end else if (i_fwd & ~fwd_d_ff) begin
            dir_ff <= 1'b0;
        end else if (cmd_ff[CMD_START]) begin
            dir_ff <= cmd_ff[CMD_REV];
        end
    end

    // ------------------------------------------------
    // Flags and outputs
    // ------------------------------------------------
    logic halt_ff, ramp_ff, drv_ff;
    logic refhi_fl_ff, reflo_fl_ff, spdhi_fl_ff, spdlo_fl_ff, warn_ff;
    dfs_state_e stat_ff, nxt_stat;
    logic [7:0] wnum_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            halt_ff <= 1'b0;
            ramp_ff <= 1'b0;
            drv_ff <= 1'b0;
        end else begin
            halt_ff <= ~i_halt_n | qstop_ser_ff;
            drv_ff <= ~faulted & (run_ff == DFS_RS_RUN) & ~halt_ff;
            ramp_ff <= ~faulted & (drv_ff ? (motor_speed != ref_sum)
                : (motor_speed != 16'h0));
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            refhi_fl_ff <= 1'b0;
            reflo_fl_ff <= 1'b0;
            spdhi_fl_ff <= 1'b0;
            spdlo_fl_ff <= 1'b0;
            warn_ff <= 1'b0;
            wnum_ff <= 8'h00;
        end else begin
            refhi_fl_ff <= ref_sum > refhi_ff;
            reflo_fl_ff <= ref_sum < reflo_ff;
            spdhi_fl_ff <= motor_speed > spdhi_ff;
            spdlo_fl_ff <= motor_speed < spdlo_ff;
            warn_ff <= warn_cond | supply_low;
            wnum_ff <= supply_low ? WARN_NUM_SUPPLY : warn_code;
        end
    end

    always_comb begin
        if (lock_ff) begin
            nxt_stat = DFS_ST_LOCK;
        end else if (trip_ff) begin
            nxt_stat = DFS_ST_TRIP;
        end else if (derate_ff) begin
            nxt_stat = DFS_ST_DERATE;
        end else if (halt_ff && motor_speed != 16'h0) begin
            nxt_stat = DFS_ST_QSTOP;
        end else if (stop_lvl) begin
            nxt_stat = DFS_ST_STOP;
        end else begin
            unique case (run_ff)
                DFS_RS_PEND: nxt_stat = DFS_ST_RUNREQ;
                DFS_RS_DELAY: nxt_stat = DFS_ST_DELAY;
                DFS_RS_RUN: nxt_stat = DFS_ST_RUN;
                DFS_RS_SLEEP: nxt_stat = DFS_ST_SLEEP;
                default: nxt_stat = auto_mode ? DFS_ST_STANDBY : DFS_ST_STOP;
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            stat_ff <= DFS_ST_STOP;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    // Blink timer; drives only the alarm light, disp_flash is a steady level
    logic [31:0] blk_cnt_ff;
    logic blink_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            blk_cnt_ff <= 32'h0;
            blink_ff <= 1'b0;
        end else if (blk_cnt_ff >= 32'(BLINK_CYCLES - 1)) begin
            blk_cnt_ff <= 32'h0;
            blink_ff <= ~blink_ff;
        end else begin
            blk_cnt_ff <= blk_cnt_ff + 32'h1;
        end
    end

    logic lw_ff, la_ff, dfl_ff;
    logic [7:0] dcode_ff;
    always_ff @(posedge clock) begin
        if (rst) begin
            lw_ff <= 1'b0;
            la_ff <= 1'b0;
            dfl_ff <= 1'b0;
            dcode_ff <= 8'h00;
        end else begin
            lw_ff <= lock_ff | (warn_ff & ~trip_ff);
            la_ff <= faulted & blink_ff;
            dfl_ff <= faulted;
            dcode_ff <= faulted ? alarm_num_ff : (warn_ff ? wnum_ff : 8'h00);
        end
    end

    assign drive_en = drv_ff;
    assign fast_halt_ramp = halt_ff;
    assign ramping = ramp_ff;
    assign dir_rev = dir_ff;
    assign switch_freq = derate_ff ? SW_HZ_DERATE : SW_HZ_NORMAL;
    assign op_status = stat_ff;
    assign disp_code = dcode_ff;
    assign disp_flash = dfl_ff;
    assign light_power = 1'b1;
    assign light_warn = lw_ff;
    assign light_alarm = la_ff;

    // Read mux
    always_ff @(posedge clock) begin
        if (rst) begin
            avs_readdata <= 32'h0;
        end else if (rd_hit) begin
            unique case (avs_address)
                ADDR_CTRL: avs_readdata <= {29'h0, ctrl_ff};
                ADDR_REFHI: avs_readdata <= {16'h0, refhi_ff};
                ADDR_REFLO: avs_readdata <= {16'h0, reflo_ff};
                ADDR_SPDHI: avs_readdata <= {16'h0, spdhi_ff};
                ADDR_SPDLO: avs_readdata <= {16'h0, spdlo_ff};
                ADDR_DELAY: avs_readdata <= delay_ff;
                ADDR_STATUS: avs_readdata <= {22'h0, stat_ff};
                ADDR_FLAGS: avs_readdata <= {24'h0, run_ff == DFS_RS_PEND,
                    dir_ff, derate_ff, warn_ff, spdlo_fl_ff, spdhi_fl_ff,
                    reflo_fl_ff, refhi_fl_ff};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    AST_DERATE_FREQ: assert property (
        @(posedge clock) disable iff (rst)
        crit_overstress && !faulted && !inv_fault_trip && !derate_ff
        |=> derate_ff && switch_freq == SW_HZ_DERATE)
        else $error("derating not entered");
    AST_TRIP_COAST: assert property (
        @(posedge clock) disable iff (rst)
        faulted |=> !drive_en)
        else $error("drive active during trip");
    AST_TRIP_SET: assert property (
        @(posedge clock) disable iff (rst)
        alarm_req |=> (trip_ff | lock_ff))
        else $error("alarm did not trip");
    AST_LOCK_HOLD: assert property (
        @(posedge clock) disable iff (rst)
        lock_ff && !armed_ff && !power_cycled |=> lock_ff)
        else $error("lock cleared without power cycle");
    AST_LOCK_PRIO: assert property (
        @(posedge clock) disable iff (rst)
        lock_ff |=> op_status == DFS_ST_LOCK)
        else $error("lock not reported");
    AST_LIGHTS: assert property (
        @(posedge clock) disable iff (rst)
        lock_ff |=> light_warn)
        else $error("lock without warning light");
    AST_TRIP_LIGHT: assert property (
        @(posedge clock) disable iff (rst)
        trip_ff && !lock_ff |=> !light_warn)
        else $error("warning light on during trip");
    AST_PEND: assert property (
        @(posedge clock) disable iff (rst)
        run_ff == DFS_RS_PEND |-> !drive_en)
        else $error("drive while awaiting permissive");
    AST_REFHI: assert property (
        @(posedge clock) disable iff (rst)
        ref_sum > refhi_ff |=> refhi_fl_ff)
        else $error("reference high flag missing");
    AST_HALT: assert property (
        @(posedge clock) disable iff (rst)
        !i_halt_n |=> fast_halt_ramp)
        else $error("fast halt ramp not selected");
endmodule : dfs_supervisor
`default_nettype wire
